// >>> design/pcs_pkg.sv
// Package for the 16-bit card socket control block
package pcs_pkg;
   // Cycle kinds requested by the host side
   typedef enum logic [1:0] {
      PCS_MEM_RD = 2'h0,
      PCS_MEM_WR = 2'h1,
      PCS_IO_RD  = 2'h2,
      PCS_IO_WR  = 2'h3
   } pcs_kind_t;

   // Sequencer states
   typedef enum logic [2:0] {
      PCS_IDLE,
      PCS_SETUP,
      PCS_STROBE,
      PCS_HOLD
   } pcs_state_t;

   // Timing, in ns, and derived cycle counts at 250 MHz
   localparam int PCS_CLK_PERIOD_NS = 4;
   localparam int PCS_SETUP_NS      = 20;
   localparam int PCS_STROBE_NS     = 100;
   localparam int PCS_HOLD_NS       = 20;
   localparam logic [7:0] PCS_SETUP_CYC  =
      8'((PCS_SETUP_NS + PCS_CLK_PERIOD_NS - 1) / PCS_CLK_PERIOD_NS);
   localparam logic [7:0] PCS_STROBE_CYC =
      8'((PCS_STROBE_NS + PCS_CLK_PERIOD_NS - 1) / PCS_CLK_PERIOD_NS);
   localparam logic [7:0] PCS_HOLD_CYC   =
      8'((PCS_HOLD_NS + PCS_CLK_PERIOD_NS - 1) / PCS_CLK_PERIOD_NS);
   localparam logic [7:0] PCS_CNT_ONE    = 8'h01;
   localparam logic [7:0] PCS_CNT_ZERO   = 8'h00;

   // Host request
   typedef struct packed {
      logic      valid;
      pcs_kind_t kind;
      logic      attr;
   } pcs_req_t;

   // Card strobes, active low except the card reset, which is active high
   typedef struct packed {
      logic oe_n;
      logic we_n;
      logic iord_n;
      logic iowr_n;
      logic reg_n;
      logic reset;
   } pcs_strb_t;

   // Synchronised card inputs: ready/irq, wait_n, wp/io16, vs1, vs2
   typedef struct packed {
      logic rdy_irq;
      logic wait_n;
      logic wp_io16;
      logic vs1;
      logic vs2;
   } pcs_pins_t;

   // Sequencer and synchroniser state of the block; status flops are separate
   typedef struct packed {
      pcs_state_t state;
      logic [7:0] cnt;
      pcs_kind_t  kind;
      logic       attr;
      pcs_strb_t  strb;
      pcs_pins_t  s1;
      pcs_pins_t  s2;
      pcs_pins_t  s3;
      pcs_pins_t  stab;
      logic       done;
      logic       io16_cap;
   } pcs_regs_t;

   // Strobe idle value: all high, card reset low
   localparam pcs_strb_t PCS_STRB_IDLE = '{oe_n: 1'b1, we_n: 1'b1, iord_n: 1'b1,
                                           iowr_n: 1'b1, reg_n: 1'b1, reset: 1'b0};
endpackage

// >>> design/pcs_socket_ctrl.sv
// Control strobes and status for one 16-bit card socket
`timescale 1ns/10ps
// How it works
// - Memory read drives output enable low
// - Ready in memory mode, interrupt in I/O
// - Attribute select high for common memory
// - Attribute select reaches attribute or I/O only
// - Card reset output forces hard reset
// - Both voltage-sense lines decoded together
// - Wait active holds the cycle open
// - Memory write pulses write enable
// - I/O mode reads that pin as 16-bit port
// - I/O read asserts I/O read strobe
// - I/O write drives I/O write strobe low
module pcs_socket_ctrl
   import pcs_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // Host side
   input  wire pcs_req_t   req,
   input  wire logic       io_mode,
   input  wire logic       card_reset_req,
   output logic            req_ready,
   output logic            cyc_done,
   output logic            cyc_16bit,
   // Card side
   input  wire pcs_pins_t  pins,
   output pcs_strb_t       strb,
   // Status
   output logic            card_busy,
   output logic            card_irq,
   output logic            wr_protect,
   output logic [1:0]      vsense
);
   pcs_regs_t r_q;   // Registered state
   pcs_regs_t r_d;   // Next state

   // Next-state logic
   always_comb begin
      r_d      = r_q;
      r_d.done = 1'b0;
      // Three-stage sync, accept once second and third agree
      r_d.s1 = pins;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      for (int i = 0; i < $bits(pcs_pins_t); i++) begin
         if (r_q.s2[i] == r_q.s3[i]) begin
            r_d.stab[i] = r_q.s3[i];
         end
      end
      r_d.strb.reset = card_reset_req;
      case (r_q.state)
         PCS_IDLE: begin
            r_d.strb = PCS_STRB_IDLE;
            r_d.strb.reset = card_reset_req;
            if (req.valid && !card_reset_req) begin
               r_d.kind  = req.kind;
               r_d.attr  = req.attr;
               // Attribute select only for attribute or I/O space
               r_d.strb.reg_n = !(req.attr || req.kind[1]);
               r_d.cnt   = PCS_SETUP_CYC;
               r_d.state = PCS_SETUP;
            end
         end
         PCS_SETUP: begin
            if (r_q.cnt > PCS_CNT_ONE) begin
               r_d.cnt = r_q.cnt - PCS_CNT_ONE;
            end else begin
               // Exactly one strobe family at a time
               case (r_q.kind)
                  PCS_MEM_RD: r_d.strb.oe_n   = 1'b0;
                  PCS_MEM_WR: r_d.strb.we_n   = 1'b0;
                  PCS_IO_RD:  r_d.strb.iord_n = 1'b0;
                  PCS_IO_WR:  r_d.strb.iowr_n = 1'b0;
                  default:    r_d.strb.oe_n   = 1'b1;
               endcase
               r_d.cnt   = PCS_STROBE_CYC;
               r_d.state = PCS_STROBE;
            end
         end
         PCS_STROBE: begin
            // Port size from IOIS16 sampled in I/O mode
            r_d.io16_cap = io_mode && r_q.kind[1] && !r_q.stab.wp_io16;
            if (r_q.cnt > PCS_CNT_ONE) begin
               r_d.cnt = r_q.cnt - PCS_CNT_ONE;
            end else if (r_q.stab.wait_n) begin
               r_d.strb.oe_n   = 1'b1;
               r_d.strb.we_n   = 1'b1;
               r_d.strb.iord_n = 1'b1;
               r_d.strb.iowr_n = 1'b1;
               r_d.cnt   = PCS_HOLD_CYC;
               r_d.state = PCS_HOLD;
            end
         end
         PCS_HOLD: begin
            if (r_q.cnt > PCS_CNT_ONE) begin
               r_d.cnt = r_q.cnt - PCS_CNT_ONE;
            end else begin
               r_d.strb.reg_n = 1'b1;
               r_d.done  = 1'b1;
               r_d.cnt   = PCS_CNT_ZERO;
               r_d.state = PCS_IDLE;
            end
         end
         default: begin
            r_d.state = PCS_IDLE;
            r_d.strb  = PCS_STRB_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         r_q          <= '0;
         r_q.state    <= PCS_IDLE;
         r_q.strb     <= PCS_STRB_IDLE;
         r_q.s1       <= '1;
         r_q.s2       <= '1;
         r_q.s3       <= '1;
         r_q.stab     <= '1;
      end else begin
         r_q <= r_d;
      end
   end

   // Status flops, all registered
   logic busy_q;
   logic irq_q;
   logic wp_q;
   logic [1:0] vs_q;
   logic rdy_q;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         irq_q  <= 1'b0;
         wp_q   <= 1'b0;
         vs_q   <= 2'h3;
         rdy_q  <= 1'b0;
      end else begin
         busy_q <= !io_mode && !r_q.stab.rdy_irq;
         irq_q  <= io_mode && !r_q.stab.rdy_irq;
         wp_q   <= !io_mode && r_q.stab.wp_io16;
         vs_q   <= {r_q.stab.vs2, r_q.stab.vs1};
         rdy_q  <= (r_d.state == PCS_IDLE) && !card_reset_req;
      end
   end

   assign strb       = r_q.strb;
   assign cyc_done   = r_q.done;
   assign cyc_16bit  = r_q.io16_cap;
   assign card_busy  = busy_q;
   assign card_irq   = irq_q;
   assign wr_protect = wp_q;
   assign vsense     = vs_q;
   assign req_ready  = rdy_q;

   // Strobe exclusivity
   mem_io_excl_a: assert property (@(posedge clock) disable iff (sys_rst)
      !((!strb.oe_n || !strb.we_n) && (!strb.iord_n || !strb.iowr_n)))
      else $error("memory and I/O strobes together");
   // Common memory keeps attribute select high
   common_reg_a: assert property (@(posedge clock) disable iff (sys_rst)
      ((!strb.oe_n || !strb.we_n) && !r_q.attr) |-> strb.reg_n)
      else $error("attribute select low on common access");
   // Strobe held while wait is active
   wait_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
      (r_q.state == PCS_STROBE && r_q.cnt <= PCS_CNT_ONE && !r_q.stab.wait_n) |=> (r_q.state == PCS_STROBE))
      else $error("cycle ended under wait");
   sequence strobe_start_s;
      r_q.state == PCS_SETUP && r_q.cnt == PCS_CNT_ONE;
   endsequence
   mem_rd_oe_a: assert property (@(posedge clock) disable iff (sys_rst)
      (strobe_start_s and r_q.kind == PCS_MEM_RD) |=> !strb.oe_n)
      else $error("output enable missing on memory read");
   mem_wr_we_a: assert property (@(posedge clock) disable iff (sys_rst)
      (strobe_start_s and r_q.kind == PCS_MEM_WR) |=> !strb.we_n ##24 !strb.we_n)
      else $error("write enable pulse wrong");
   io_rd_a: assert property (@(posedge clock) disable iff (sys_rst)
      (strobe_start_s and r_q.kind == PCS_IO_RD) |=> !strb.iord_n)
      else $error("I/O read strobe missing");
   io_wr_a: assert property (@(posedge clock) disable iff (sys_rst)
      (strobe_start_s and r_q.kind == PCS_IO_WR) |=> !strb.iowr_n)
      else $error("I/O write strobe missing");
   reset_out_a: assert property (@(posedge clock) disable iff (sys_rst)
      card_reset_req |=> strb.reset)
      else $error("card reset not driven");
   vsense_a: assert property (@(posedge clock) disable iff (sys_rst)
      $stable(r_q.stab) |=> (vsense == $past({r_q.stab.vs2, r_q.stab.vs1})))
      else $error("voltage sense mismatch");
   // Card reset blocks new host cycles
   reset_block_a: assert property (@(posedge clock) disable iff (sys_rst)
      card_reset_req |=> !req_ready)
      else $error("request accepted during card reset");
   // Busy status only in memory mode
   busy_mode_a: assert property (@(posedge clock) disable iff (sys_rst)
      io_mode |=> !card_busy)
      else $error("busy shown in I/O mode");
   // Write-protect status only in memory mode
   wp_mode_a: assert property (@(posedge clock) disable iff (sys_rst)
      io_mode |=> !wr_protect)
      else $error("write protect shown in I/O mode");
   // I/O strobes always with attribute select low
   attr_io_a: assert property (@(posedge clock) disable iff (sys_rst)
      (!strb.iord_n || !strb.iowr_n) |-> !strb.reg_n)
      else $error("I/O strobe without attribute select");
endmodule

// >>> verification/pcs_card_model.sv
// Behavioural model of a 16-bit card sitting in the socket
`timescale 1ns/10ps
module pcs_card_model
   import pcs_pkg::*;
#(
   parameter int BUSY_CYC = 40
)
(
   // Clock and strobes
   input  wire logic       clock,
   input  wire pcs_strb_t  strb,
   // Card setup
   input  wire logic       io_mode,
   input  wire logic       irq_req,
   input  wire logic       wp_sw,
   input  wire logic       port16,
   input  wire logic [7:0] wait_cyc,
   input  wire logic [1:0] vs_code,
   // Card pins
   output pcs_pins_t       pins,
   output logic            inp_ack
);
   logic [7:0] busy_q = 8'h00; // Busy countdown
   logic [7:0] wait_q = 8'h00; // Wait countdown
   logic       we_n_q = 1'b1;
   logic       act_q  = 1'b0;
   wire        act    = !(strb.oe_n & strb.we_n & strb.iord_n & strb.iowr_n);
   wire        io_act = !(strb.iord_n & strb.iowr_n);
   // Busy after a write, wait from each strobe fall
   always @(posedge clock) begin
      we_n_q <= strb.we_n;
      act_q  <= act;
      if (!io_mode && strb.we_n && !we_n_q) begin
         busy_q <= BUSY_CYC[7:0];
      end else if (busy_q != 8'h00) begin
         busy_q <= busy_q - 8'h01;
      end
      if (act && !act_q) begin
         wait_q <= wait_cyc;
      end else if (wait_q != 8'h00) begin
         wait_q <= wait_q - 8'h01;
      end
   end
   // Pin levels
   assign pins.rdy_irq = io_mode ? !irq_req : (busy_q == 8'h00);
   assign pins.wait_n  = (wait_q == 8'h00);
   assign pins.wp_io16 = io_mode ? !(port16 && io_act) : wp_sw;
   // Acknowledge an I/O read this card can answer
   assign inp_ack      = io_mode && !strb.iord_n;
   assign pins.vs1     = vs_code[0];
   assign pins.vs2     = vs_code[1];
endmodule

// >>> verification/test_pcs_socket_ctrl.sv
// Testbench of the socket control block
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_pcs_socket_ctrl
   import pcs_pkg::*;
;
   logic       clock = 1'b0, sys_rst = 1'b1, io_mode = 1'b0, card_reset_req = 1'b0;
   logic       irq_req = 1'b0, wp_sw = 1'b0, port16 = 1'b0;
   logic [7:0] wait_cyc = 8'h00;
   logic [1:0] vs_code = 2'h1;
   pcs_req_t   req = '0;
   logic       req_ready, cyc_done, cyc_16bit, card_busy, card_irq, wr_protect;
   logic [1:0] vsense;
   pcs_pins_t  pins;
   logic       inp_ack, ack_seen = 1'b0;
   pcs_strb_t  strb, lo;
   int         err_count = 0, num_checks = 0, n0, n1;
   // Clock
   always #2 clock = ~clock;
   pcs_socket_ctrl DUT (.clock(clock), .sys_rst(sys_rst), .req(req), .io_mode(io_mode),
      .card_reset_req(card_reset_req), .req_ready(req_ready), .cyc_done(cyc_done), .cyc_16bit(cyc_16bit),
      .pins(pins), .strb(strb), .card_busy(card_busy), .card_irq(card_irq), .wr_protect(wr_protect),
      .vsense(vsense));
   pcs_card_model card (.clock(clock), .strb(strb), .io_mode(io_mode), .irq_req(irq_req), .wp_sw(wp_sw),
      .port16(port16), .wait_cyc(wait_cyc), .vs_code(vs_code), .pins(pins), .inp_ack(inp_ack));
   // Remember any acknowledge from the card
   always @(posedge clock) begin
      if (inp_ack) begin
         ack_seen <= 1'b1;
      end
   end
   // Wait n cycles, then step past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // One host cycle; lo gathers every strobe seen low, n counts cycles from take to done
   task automatic run_cyc(input pcs_kind_t k, input logic a, output pcs_strb_t lo, output int n);
      lo = '1;
      n = 0;
      while (req_ready !== 1'b1 && n < 99) begin tick(1); n++; end
      @(posedge clock);
      req <= '{1'b1, k, a};
      @(posedge clock);
      req.valid <= 1'b0;
      n = 0;
      do begin
         tick(1);
         lo = lo & strb;
         `CHK(!(strb.oe_n & strb.we_n) && !(strb.iord_n & strb.iowr_n), 1'b0)
         n++;
      end while (cyc_done !== 1'b1 && n < 400);
      `CHK(n >= int'(PCS_SETUP_CYC + PCS_STROBE_CYC + PCS_HOLD_CYC) && n < 400, 1'b1)
   endtask
   // Memory read, attribute write, busy afterwards
   task automatic t_mem;
      run_cyc(PCS_MEM_RD, 1'b0, lo, n0);
      `CHK({lo.oe_n, lo.we_n}, 2'h1)
      `CHK(lo.reg_n, 1'b1)
      run_cyc(PCS_MEM_WR, 1'b1, lo, n0);
      `CHK({lo.oe_n, lo.we_n}, 2'h2)
      `CHK(lo.reg_n, 1'b0)
      tick(2);
      `CHK(card_busy, 1'b1)
      tick(60);
      `CHK(card_busy, 1'b0)
   endtask
   // I/O read on a 16-bit port, I/O write on an 8-bit one
   task automatic t_io;
      io_mode <= 1'b1;
      port16  <= 1'b1;
      run_cyc(PCS_IO_RD, 1'b0, lo, n0);
      `CHK({lo.iord_n, lo.iowr_n, lo.oe_n, lo.reg_n}, 4'h6)
      `CHK(cyc_16bit, 1'b1)
      `CHK(ack_seen, 1'b1)
      port16 <= 1'b0;
      run_cyc(PCS_IO_WR, 1'b0, lo, n0);
      `CHK({lo.iord_n, lo.iowr_n, lo.we_n}, 3'h5)
      `CHK(cyc_16bit, 1'b0)
   endtask
   // Wait from the card stretches the cycle
   task automatic t_wait;
      io_mode <= 1'b0;
      run_cyc(PCS_MEM_RD, 1'b0, lo, n0);
      wait_cyc <= 8'h3c;
      run_cyc(PCS_MEM_RD, 1'b0, lo, n1);
      wait_cyc <= 8'h00;
      `CHK(n1 > n0 + 30, 1'b1)
   endtask
   // Status pins in both modes
   task automatic t_status;
      wp_sw   <= 1'b1;
      vs_code <= 2'h2;
      tick(8);
      `CHK({wr_protect, vsense}, 3'h6)
      io_mode <= 1'b1;
      irq_req <= 1'b1;
      tick(8);
      `CHK({card_irq, card_busy, wr_protect}, 3'h4)
      irq_req <= 1'b0;
      tick(8);
      `CHK(card_irq, 1'b0)
   endtask
   // Card reset output
   task automatic t_card_rst;
      card_reset_req <= 1'b1;
      tick(3);
      `CHK({strb.reset, req_ready}, 2'h2)
      card_reset_req <= 1'b0;
      tick(3);
      `CHK(strb.reset, 1'b0)
   endtask
   // Verdict and end of run
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #80000;
      err_count++;
      print_verdict();
   end
   // Main sequence
   initial begin
      tick(15);
      `CHK({strb, vsense, req_ready}, {PCS_STRB_IDLE, 2'h3, 1'b0})
      @(posedge clock);
      sys_rst <= 1'b0;
      tick(2);
      `CHK(req_ready, 1'b1)
      t_mem();
      t_io();
      t_wait();
      t_status();
      t_card_rst();
      print_verdict();
   end
endmodule
